// *** inc/buck_seq_pkg.sv ***
// constants, types and layouts for the dual buck fault sequencer
// Behaviour
// - no switching below input supply threshold
// - supply drop disables channel until return
// - both enables low: shutdown, switches hi-z
// - enable rise starts 2 ms soft-start
// - enable fall shuts channel down
// - good flag low while disabled or ramping
// - good flag released above 90 percent
// - good flag pulled low below 90 percent
// - fault keeps good flag low until restart
// - overcurrent: counter one, flag, chop switch
// - 17 overcurrent cycles: fault, shutdown
// - wait eight ramps, clear, retry soft-start
// - overflow during retry repeats the hiccup
// - hot shutdown, restart after 20 degree cooling
// - low bootstrap: 400 ns refresh pulse
// - floating enable waits for other channel good
// - both enables high start together
package buck_seq_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 20;
  localparam int SS_TIME_US     = 2000;
  localparam int SW_FREQ_KHZ    = 500;
  localparam int SS_TICKS_DEF   = SS_TIME_US * SW_FREQ_KHZ / 1000;
  localparam int HICCUP_PERIODS = 8;
  localparam int OC_LIMIT       = 17;
  localparam int REFRESH_NS     = 400;
  localparam int REFRESH_CYCLES = (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_W           = 5;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [1:0] CTRL_RESET  = 2'h3;

  typedef enum logic [2:0] {
    CH_OFF    = 3'h0,
    CH_SOFT   = 3'h1,
    CH_RUN    = 3'h2,
    CH_HICCUP = 3'h3
  } chan_state_t;

  // comparator and pin levels from outside the clock domain
  typedef struct packed {
    logic       supply_ok;
    logic [1:0] enable;
    logic [1:0] en_float;
    logic [1:0] fb_good;
    logic [1:0] oc_over;
    logic       hot;
    logic       cooled;
    logic [1:0] boot_low;
    logic       sw_tick;
    logic [1:0] good_pin;
  } pins_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [10:0]     rsv;
    logic [1:0]      good_pin;
    logic [OC_W-1:0] oc_b;
    logic [OC_W-1:0] oc_a;
    logic [1:0]      fault;
    logic            therm;
    logic [2:0]      st_b;
    logic [2:0]      st_a;
  } status_t;

endpackage : buck_seq_pkg

// *** core/dual_buck_fault_sequencer.sv ***
// control and fault sequencing for a two-channel step-down regulator
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module dual_buck_fault_sequencer
  import buck_seq_pkg::*;
#(
  parameter int SS_TICKS = SS_TICKS_DEF,
  parameter int CNT_W    = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire pins_t       pins_i,
  input  wire wb_req_t     wb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic [1:0]       gate_on_o,
  output logic [1:0]       gate_oe_o,
  output logic [1:0]       refresh_o,
  output logic [1:0]       good_out_o,
  output logic [1:0]       good_oe_o
);

  localparam int HIC_TICKS = HICCUP_PERIODS * SS_TICKS;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************************************
  // pin synchronisers and switching tick
  // ****************************************************************
  pins_t meta_q;
  pins_t sync_q;
  logic  tick_prev_q;
  logic  tick;

  // two flops on every outside level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q      <= '0;
      sync_q      <= '0;
      tick_prev_q <= 1'b0;
    end else if (ce_i) begin
      meta_q      <= pins_i;
      sync_q      <= meta_q;
      tick_prev_q <= sync_q.sw_tick;
    end
  end

  assign tick = sync_q.sw_tick & ~tick_prev_q;  // one switching cycle starts

  // ****************************************************************
  // thermal latch and register file
  // ****************************************************************
  logic        therm_q;
  logic        therm_d;
  logic [1:0]  ctrl_q;
  logic [1:0]  ctrl_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  status_t     status;

  chan_state_t     st_q   [2];
  logic [OC_W-1:0] occ_q  [2];
  logic [OC_W-1:0] occ_d  [2];
  logic            fault_q [2];
  logic            fault_d [2];

  always_comb begin
    status          = '0;
    status.good_pin = sync_q.good_pin;
    status.oc_b     = occ_q[1];
    status.oc_a     = occ_q[0];
    status.fault    = {fault_q[1], fault_q[0]};
    status.therm    = therm_q;
    status.st_b     = st_q[1];
    status.st_a     = st_q[0];
  end

  // next values for thermal latch and bus slave
  always_comb begin
    therm_d = therm_q;
    if (sync_q.hot) begin
      therm_d = 1'b1;
    end else if (sync_q.cooled) begin
      therm_d = 1'b0;
    end
    ack_d  = wb_i.cyc & wb_i.stb & ~ack_q;
    ctrl_d = ctrl_q;
    if (ack_q && wb_i.cyc && wb_i.stb && wb_i.we && wb_i.adr == ADDR_CTRL && wb_i.sel[0]) begin
      ctrl_d = wb_i.dat[1:0];
    end
    dat_d = dat_q;
    if (ack_d) begin
      case (wb_i.adr)
        ADDR_CTRL:   dat_d = {30'h0000_0000, ctrl_q};
        ADDR_STATUS: dat_d = status;
        default:     dat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      therm_q <= 1'b0;
      ctrl_q  <= CTRL_RESET;
      ack_q   <= 1'b0;
      dat_q   <= 32'h0000_0000;
    end else if (ce_i) begin
      therm_q <= therm_d;
      ctrl_q  <= ctrl_d;
      ack_q   <= ack_d;
      dat_q   <= dat_d;
    end
  end

  assign wb_ack_o   = ack_q;
  assign wb_dat_o   = dat_q;
  assign good_out_o = 2'h0;  // open drain, only ever pulls low

  // ****************************************************************
  // per-channel sequencer
  // ****************************************************************
  logic [1:0] run_good;
  logic [1:0] en_eff;
  logic [1:0] active;

  for (genvar i = 0; i < 2; i++) begin : g_chan
    localparam int J = 1 - i;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] rfc_q;
    logic [CNT_W-1:0] rfc_d;
    logic             chop_q;
    logic             chop_d;
    logic             flag_q;
    logic             flag_d;
    logic             rf_q;
    logic             rf_d;
    logic             good_q;
    logic             good_d;
    logic             oc_hit;
    logic [OC_W-1:0]  occ_base;
    chan_state_t      st_d;

    assign run_good[i] = (st_q[i] == CH_RUN) & sync_q.fb_good[i];
    assign active[i]   = (st_q[i] == CH_SOFT) | (st_q[i] == CH_RUN);
    assign oc_hit      = active[i] & ~chop_q & sync_q.oc_over[i];

    // supply, heat and software gate the enable
    // a floating enable follows the other channel
    assign en_eff[i] = sync_q.supply_ok & ~therm_q & ctrl_q[i] &
                       (sync_q.en_float[i] ?
                        (~sync_q.en_float[J] & sync_q.enable[J] & run_good[J]) :
                        sync_q.enable[i]);

    // next state, counters and overcurrent bookkeeping
    always_comb begin
      st_d       = st_q[i];
      cnt_d      = cnt_q;
      occ_d[i]   = occ_q[i];
      fault_d[i] = fault_q[i];
      chop_d     = chop_q;
      flag_d     = flag_q;
      rf_d       = rf_q;
      rfc_d      = rfc_q;
      occ_base   = (tick && !chop_q) ? '0 : occ_q[i];
      // chop the switch and count overcurrent cycles
      if (active[i]) begin
        if (tick) begin
          chop_d = 1'b0;
        end
        if (oc_hit) begin
          chop_d   = 1'b1;
          flag_d   = 1'b1;
          occ_d[i] = occ_base + 1'b1;
        end else if (tick) begin
          occ_d[i] = occ_base;
        end
      end
      case (st_q[i])
        CH_OFF: begin
          cnt_d    = '0;
          occ_d[i] = '0;
          chop_d   = 1'b0;
          flag_d   = 1'b0;
          if (en_eff[i]) begin
            st_d       = CH_SOFT;
            fault_d[i] = 1'b0;
          end
        end
        CH_SOFT: begin
          if (tick) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(SS_TICKS - 1)) begin
              st_d  = CH_RUN;
              cnt_d = '0;
            end
          end
        end
        CH_RUN: begin
          cnt_d = '0;
        end
        CH_HICCUP: begin
          chop_d = 1'b0;
          if (tick) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(HIC_TICKS - 1)) begin
              st_d       = CH_SOFT;
              cnt_d      = '0;
              occ_d[i]   = '0;
              flag_d     = 1'b0;
              fault_d[i] = 1'b0;
            end
          end
        end
        default: begin
          st_d = CH_OFF;
        end
      endcase
      // overflow declares a fault and starts the hiccup
      if (active[i] && occ_d[i] == OC_W'(OC_LIMIT)) begin
        st_d       = CH_HICCUP;
        cnt_d      = '0;
        chop_d     = 1'b0;
        fault_d[i] = 1'b1;
      end
      // loss of enable or supply shuts the channel
      if (!en_eff[i]) begin
        st_d  = CH_OFF;
        cnt_d = '0;
        if (therm_q) begin
          fault_d[i] = 1'b1;
        end
      end
      // bootstrap refresh pulse of fixed length
      if (rf_q) begin
        rfc_d = rfc_q + 1'b1;
        if (rfc_q == CNT_W'(REFRESH_CYCLES - 1)) begin
          rf_d  = 1'b0;
          rfc_d = '0;
        end
      end else if (sync_q.boot_low[i] && st_q[i] != CH_OFF) begin
        rf_d  = 1'b1;
        rfc_d = '0;
      end
      if (st_d == CH_OFF) begin
        rf_d  = 1'b0;
        rfc_d = '0;
      end
      // good flag from state, feedback and fault
      good_d = (st_q[i] == CH_RUN) & sync_q.fb_good[i] & ~fault_q[i];
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        st_q[i]    <= CH_OFF;
        cnt_q      <= '0;
        occ_q[i]   <= '0;
        fault_q[i] <= 1'b0;
        chop_q     <= 1'b0;
        flag_q     <= 1'b0;
        rf_q       <= 1'b0;
        rfc_q      <= '0;
        good_q     <= 1'b0;
      end else if (ce_i) begin
        st_q[i]    <= st_d;
        cnt_q      <= cnt_d;
        occ_q[i]   <= occ_d[i];
        fault_q[i] <= fault_d[i];
        chop_q     <= chop_d;
        flag_q     <= flag_d;
        rf_q       <= rf_d;
        rfc_q      <= rfc_d;
        good_q     <= good_d;
      end
    end

    // switch permission and drive, hi-z whenever off
    assign gate_on_o[i] = active[i] & ~chop_q & ~rf_q;
    assign gate_oe_o[i] = active[i] | rf_q;
    assign refresh_o[i] = rf_q;
    assign good_oe_o[i] = ~good_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_UVLO_OFF: assert property (ce_i && !sync_q.supply_ok |=> st_q[i] == CH_OFF)
      else $error("channel not off while supply is low");
    AST_SHUTDOWN_HIZ: assert property (ce_i && !sync_q.enable[0] && !sync_q.enable[1]
      && !sync_q.en_float[i] |=> !gate_oe_o[i] && !refresh_o[i])
      else $error("switch driven in shutdown");
    AST_RAMP_START: assert property (ce_i && st_q[i] == CH_OFF && en_eff[i]
      |=> st_q[i] == CH_SOFT && !fault_q[i])
      else $error("ramp did not start on enable");
    AST_DISABLE: assert property (ce_i && !en_eff[i] |=> st_q[i] == CH_OFF ##0 !gate_oe_o[i])
      else $error("channel not shut down on enable loss");
    AST_GOOD_LOW: assert property (ce_i && (st_q[i] != CH_RUN || fault_q[i])
      |=> good_oe_o[i])
      else $error("good flag released while ramping or faulted");
    AST_GOOD_TRACK: assert property (ce_i && st_q[i] == CH_RUN && !fault_q[i]
      |=> good_oe_o[i] == !$past(sync_q.fb_good[i]))
      else $error("good flag does not follow feedback");
    AST_OC_CHOP: assert property (ce_i && oc_hit && occ_q[i] < OC_W'(OC_LIMIT - 1)
      |=> chop_q && flag_q && !gate_on_o[i] && occ_q[i] != '0)
      else $error("overcurrent did not chop the switch");
    AST_OC_FAULT: assert property (ce_i && occ_q[i] == OC_W'(OC_LIMIT) && st_q[i] != CH_OFF
      |-> st_q[i] == CH_HICCUP && fault_q[i] ##1 good_oe_o[i])
      else $error("overflow did not start the hiccup");
    AST_HICCUP_EXIT: assert property ($past(ce_i) && st_q[i] == CH_SOFT
      && $past(st_q[i]) == CH_HICCUP
      |-> $past(cnt_q) == CNT_W'(HIC_TICKS - 1) && occ_q[i] == '0 && !flag_q)
      else $error("hiccup retry before the wait ended");
    AST_THERM_OFF: assert property (ce_i && therm_q |=> st_q[i] == CH_OFF)
      else $error("channel running while hot");
    AST_REFRESH_LEN: assert property ($fell(rf_q) && st_q[i] != CH_OFF
      |-> $past(rfc_q) == CNT_W'(REFRESH_CYCLES - 1))
      else $error("refresh pulse of wrong length");
    AST_SEQ_HOLD: assert property (ce_i && sync_q.en_float[i] && !run_good[J]
      |=> st_q[i] == CH_OFF)
      else $error("floating channel started before the other was good");
    COV_RUN: cover property (st_q[i] == CH_SOFT ##1 st_q[i] == CH_RUN);
    COV_HICCUP: cover property (st_q[i] == CH_RUN ##1 st_q[i] == CH_HICCUP);
    COV_RETRY: cover property (st_q[i] == CH_HICCUP ##1 st_q[i] == CH_SOFT);
    COV_REFRESH: cover property ($rose(rf_q));
  end

endmodule : dual_buck_fault_sequencer

// *** testbench/buck_stage_model.sv ***
// far-side model: switching clock source and open-drain good pins with pull-up
`timescale 1ns/100ps
module buck_stage_model #(
  parameter int TICK_HALF = 5
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] good_out_i,
  input  wire logic [1:0] good_oe_i,
  output logic            sw_tick_o,
  output logic [1:0]      good_pin_o
);
  // ****************************************************************
  // switching clock and pin levels
  // ****************************************************************
  logic [7:0] div_q;

  // free running switching clock, TICK_HALF cycles per phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q     <= 8'h00;
      sw_tick_o <= 1'b0;
    end else if (div_q == 8'(TICK_HALF - 1)) begin
      div_q     <= 8'h00;
      sw_tick_o <= ~sw_tick_o;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // released pin floats high through the pull-up
  assign good_pin_o = (good_oe_i & good_out_i) | ~good_oe_i;
endmodule : buck_stage_model

// *** testbench/dual_buck_fault_sequencer_tb_top.sv ***
// self-checking bench for the dual buck fault sequencer
`timescale 1ns/100ps
module dual_buck_fault_sequencer_tb_top;
  import buck_seq_pkg::*;
  localparam int SS = 4;
  typedef struct packed {
    logic       sup;
    logic [1:0] en;
    logic [1:0] flt;
    logic [1:0] fb;
    logic [2:0] sa;
    logic [2:0] sb;
    logic [1:0] goe;
    logic [1:0] pg;
  } row_t;
  logic        clk_i;
  logic        rst_i;
  logic        ce;
  logic [3:0]  bsel;
  pins_t       drv;
  pins_t       pins;
  wb_req_t     wb;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [1:0]  gate_on;
  logic [1:0]  gate_oe;
  logic [1:0]  refresh;
  logic [1:0]  good_out;
  logic [1:0]  good_oe;
  logic        tick;
  logic [1:0]  gpin;
  int          err_total;
  int          checks;
  status_t     st;
  logic [31:0] q;
  int          n;
  int          m;
  logic        tprev;
  row_t        rows [6] = '{
    '{1'b1, 2'h3, 2'h0, 2'h3, CH_RUN, CH_RUN, 2'h3, 2'h0},
    '{1'b1, 2'h0, 2'h0, 2'h3, CH_OFF, CH_OFF, 2'h0, 2'h3},
    '{1'b1, 2'h1, 2'h2, 2'h3, CH_RUN, CH_RUN, 2'h3, 2'h0},
    '{1'b1, 2'h1, 2'h2, 2'h0, CH_RUN, CH_OFF, 2'h1, 2'h3},
    '{1'b1, 2'h2, 2'h1, 2'h3, CH_RUN, CH_RUN, 2'h3, 2'h0},
    '{1'b0, 2'h3, 2'h0, 2'h3, CH_OFF, CH_OFF, 2'h0, 2'h3}};

  // merge bench levels with the model's tick and pin read-back
  always_comb begin
    pins          = drv;
    pins.sw_tick  = tick;
    pins.good_pin = gpin;
  end

  dual_buck_fault_sequencer #(.SS_TICKS(SS)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .pins_i(pins), .wb_i(wb),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gate_on_o(gate_on), .gate_oe_o(gate_oe),
    .refresh_o(refresh), .good_out_o(good_out), .good_oe_o(good_oe));

  buck_stage_model i_stage (
    .clk_i(clk_i), .rst_i(rst_i), .good_out_i(good_out), .good_oe_i(good_oe),
    .sw_tick_o(tick), .good_pin_o(gpin));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: bsel, dat: d};
    @(posedge clk_i iff wb_ack_o === 1'b1);
    q = wb_dat_o;
    wb.cyc <= 1'b0;
    wb.stb <= 1'b0;
  endtask : bus

  task automatic state_is(input logic [2:0] sa, input logic [2:0] sb);
    bus(1'b0, ADDR_STATUS, 32'h0);
    st = status_t'(q);
    chk("state a", 32'(sa), 32'(st.st_a));
    chk("state b", 32'(sb), 32'(st.st_b));
  endtask : state_is

  task automatic results();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // clock, 50 MHz
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // watchdog
  initial begin
    repeat (10000) @(posedge clk_i);
    err_total++;
    results();
  end

  // main sequence
  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    bsel = 4'hF;
    drv = '0;
    drv.supply_ok = 1'b1;
    wb = '0;
    err_total = 0;
    checks = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("good_oe", 32'h3, 32'(good_oe));
    chk("gate_oe", 32'h0, 32'(gate_oe));
    chk("good_out", 32'h0, 32'(good_out));
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'(CTRL_RESET), q);
    bus(1'b0, 8'h08, 32'h0);
    chk("unmapped", 32'h0, q);
    foreach (rows[i]) begin
      @(posedge clk_i);
      // enables low before re-raising, never both floating
      drv.enable <= 2'h0;
      drv.en_float <= 2'h0;
      repeat (20) @(posedge clk_i);
      drv.supply_ok <= rows[i].sup;
      drv.enable <= rows[i].en;
      drv.en_float <= rows[i].flt;
      drv.fb_good <= rows[i].fb;
      repeat (150) @(posedge clk_i);
      state_is(rows[i].sa, rows[i].sb);
      @(negedge clk_i);
      chk("gate_oe", 32'(rows[i].goe), 32'(gate_oe));
      chk("good_oe", 32'(rows[i].pg), 32'(good_oe));
      chk("good_pin", 32'(rows[i].pg ^ 2'h3), 32'(st.good_pin));
    end
    @(posedge clk_i);
    drv.enable <= 2'h0;
    drv.supply_ok <= 1'b1;
    repeat (20) @(posedge tick);
    // ramp spans SS switching ticks, good flag held low meanwhile
    @(posedge clk_i);
    drv.enable <= 2'h3;
    n = 0;
    tprev = 1'b1;
    repeat (6) @(negedge clk_i);
    chk("good_oe ramp", 32'h3, 32'(good_oe));
    chk("gate_oe ramp", 32'h3, 32'(gate_oe));
    for (m = 0; m < 200 && good_oe !== 2'h0; m++) begin
      @(negedge clk_i);
      if (tick && !tprev) n++;
      tprev = tick;
    end
    chk("ramp ticks", 32'(SS), 32'(n));
    // chop, overflow to hiccup, fault holds good flag low
    @(posedge clk_i);
    drv.oc_over <= 2'h1;
    repeat (4) @(negedge clk_i);
    chk("gate_on chop", 32'h2, 32'(gate_on));
    repeat (200) @(posedge clk_i);
    state_is(CH_HICCUP, CH_RUN);
    chk("fault", 32'h1, 32'(st.fault));
    chk("good_oe oc", 32'h1, 32'(good_oe));
    drv.oc_over <= 2'h0;
    repeat (400) @(posedge clk_i);
    state_is(CH_RUN, CH_RUN);
    chk("fault clr", 32'h0, 32'(st.fault));
    // hot shutdown with restart, supply drop with return
    drv.hot <= 1'b1;
    repeat (10) @(posedge clk_i);
    state_is(CH_OFF, CH_OFF);
    drv.hot <= 1'b0;
    drv.cooled <= 1'b1;
    repeat (150) @(posedge clk_i);
    state_is(CH_RUN, CH_RUN);
    drv.supply_ok <= 1'b0;
    repeat (10) @(posedge clk_i);
    state_is(CH_OFF, CH_OFF);
    drv.supply_ok <= 1'b1;
    repeat (150) @(posedge clk_i);
    state_is(CH_RUN, CH_RUN);
    // one low-bootstrap sample gives one timed refresh pulse
    @(posedge clk_i);
    drv.boot_low <= 2'h2;
    @(posedge clk_i);
    drv.boot_low <= 2'h0;
    n = 0;
    m = 0;
    repeat (40) begin
      @(negedge clk_i);
      n += int'(refresh[1] === 1'b1);
      m += int'(refresh[1] === 1'b1 && gate_on[1] !== 1'b0);
    end
    chk("refresh len", 32'(REFRESH_CYCLES), 32'(n));
    chk("gate_on refresh", 32'h0, 32'(m));
    // clock enable low freezes the sequencer, a supply dip is not seen
    @(posedge clk_i);
    ce <= 1'b0;
    drv.supply_ok <= 1'b0;
    repeat (10) @(negedge clk_i);
    chk("gate_oe frozen", 32'h3, 32'(gate_oe));
    @(posedge clk_i);
    ce <= 1'b1;
    drv.supply_ok <= 1'b1;
    repeat (10) @(negedge clk_i);
    chk("gate_oe thawed", 32'h3, 32'(gate_oe));
    // mid-run reset returns channels to off and ctrl to reset
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) begin
      @(negedge clk_i);
      chk("gate_oe rst", 32'h0, 32'(gate_oe));
      chk("good_oe rst", 32'h3, 32'(good_oe));
    end
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl rst", 32'(CTRL_RESET), q);
    // a write without byte lane zero is refused
    bsel = 4'hE;
    bus(1'b1, ADDR_CTRL, 32'h0);
    bsel = 4'hF;
    repeat (150) @(posedge clk_i);
    state_is(CH_RUN, CH_RUN);
    bus(1'b1, ADDR_CTRL, 32'h0);
    repeat (10) @(posedge clk_i);
    state_is(CH_OFF, CH_OFF);
    results();
  end
endmodule : dual_buck_fault_sequencer_tb_top
